// *** hdl/pcn_clock_ctrl.sv ***
// PLL control, primary tree gating and switching, edge clock sources.
// Assumes every clock input is a level sampled on clk, APB master.
// Operation
// - Reference chosen by plain two-input multiplexer
// - Feedback divider sets output multiple of reference
// - Four output dividers, each 1 to 128
// - Primary tree and edge tree output limits
// - Secondary outputs take a phase offset
// - Two-bit pick chooses adjusted output
// - Steps pend until apply loads them
// - Lock rises on lock, falls on loss
// - Lock active high, user must synchronise
// - Power-down input stops the PLL
// - Each output has its own enable
// - Four quadrants, sixteen clocks each
// - Sixty-four sources via mid and centre switches
// - Disabled quadrant clock stays static
// - Quadrant gate is glitchless, may add latency
// - Gate sits after mid, before centre
// - Dynamic switch picks one of two clocks
// - Two dynamic switches feed centre switch inputs
// - Two edge clock networks per side bank
// - Edge clock sources: pin, delay, PLL, bridge, internal
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pcn_clock_ctrl #(
	parameter int unsigned LOCK_WINDOWS = 16,
	parameter int unsigned N_EBANK = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// PLL reference and feedback
	input wire logic ref_clk_in,
	input wire logic alt_ref_clk_in,
	input wire logic feedback_clk,
	// PLL outputs
	output logic pll_primary_out,
	output logic pll_secondary_out_a,
	output logic pll_secondary_out_b,
	output logic pll_secondary_out_c,
	output logic pll_lock,
	// Primary tree
	input wire logic [pcn_pkg::N_EXT-1:0] ext_src_clk,
	input wire logic [pcn_pkg::N_DSW-1:0] fabric_centre_clk,
	output logic [pcn_pkg::N_QUAD*pcn_pkg::Q_CLKS-1:0] quad_clk,
	// Edge tree
	input wire logic [2*N_EBANK-1:0] edge_clock_tree_pin_clk,
	input wire logic edge_clock_tree_delay_clk,
	input wire logic edge_clock_tree_bridge_clk,
	input wire logic edge_clock_tree_internal_clk,
	output logic [2*N_EBANK-1:0] edge_clock_tree
);
	localparam int unsigned N_EDGE_CLOCK_TREE = 2 * N_EBANK;
	localparam int unsigned CW = $clog2(LOCK_WINDOWS + 1);
	localparam int unsigned SW0 = pcn_pkg::Q_CLKS - pcn_pkg::N_DSW; // First switchable slot

	// Register file
	logic [31:0] ctrl_q, fbdiv_q, odiv_q, phase_q;
	logic [31:0] gate_lo_q, gate_hi_q, qsel_q, dsw_q, ecl_q;
	logic [31:0] rd_mux; // Read data before register
	logic hit; // Address is mapped
	logic wr; // Write access phase
	logic [31:0] status; // Live status word

	// APB decode
	assign pready = 1'b1;
	assign wr = psel && penable && pwrite;
	assign hit = (paddr == pcn_pkg::A_CTRL) || (paddr == pcn_pkg::A_FBDIV)
		|| (paddr == pcn_pkg::A_ODIV) || (paddr == pcn_pkg::A_PHASE)
		|| (paddr == pcn_pkg::A_GATE_LO) || (paddr == pcn_pkg::A_GATE_HI)
		|| (paddr == pcn_pkg::A_QSEL) || (paddr == pcn_pkg::A_DSW)
		|| (paddr == pcn_pkg::A_EDGE_CLOCK_TREE) || (paddr == pcn_pkg::A_STATUS);
	// Unmapped address or status write answers an error
	assign pslverr = psel && penable
		&& (!hit || (pwrite && paddr == pcn_pkg::A_STATUS));

	// Phase register write strobes
	logic wr_ph; // Phase register written
	logic step_pulse; // One step requested
	logic apply_pulse; // Pending steps applied
	logic [1:0] step_pick; // Output to adjust
	logic step_dir; // One delays, zero advances
	assign wr_ph = wr && (paddr == pcn_pkg::A_PHASE);
	assign step_pulse = wr_ph && pwdata[pcn_pkg::PH_STEP];
	assign apply_pulse = wr_ph && pwdata[pcn_pkg::PH_APPLY];
	assign step_pick = pwdata[pcn_pkg::PH_PICK +: 2];
	assign step_dir = pwdata[pcn_pkg::PH_DIR];

	// Register writes take effect at the access edge
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= pcn_pkg::CTRL_INIT;
			fbdiv_q <= pcn_pkg::ZERO_INIT;
			odiv_q <= pcn_pkg::ZERO_INIT;
			phase_q <= pcn_pkg::ZERO_INIT;
			gate_lo_q <= pcn_pkg::GATE_INIT;
			gate_hi_q <= pcn_pkg::GATE_INIT;
			qsel_q <= pcn_pkg::QSEL_INIT;
			dsw_q <= pcn_pkg::DSW_INIT;
			ecl_q <= pcn_pkg::ZERO_INIT;
		end else if (wr) begin
			unique case (paddr)
				pcn_pkg::A_CTRL: ctrl_q <= pwdata;
				pcn_pkg::A_FBDIV: fbdiv_q <= pwdata;
				pcn_pkg::A_ODIV: odiv_q <= pwdata;
				pcn_pkg::A_PHASE: phase_q <= pwdata;
				pcn_pkg::A_GATE_LO: gate_lo_q <= pwdata;
				pcn_pkg::A_GATE_HI: gate_hi_q <= pwdata;
				pcn_pkg::A_QSEL: qsel_q <= pwdata;
				pcn_pkg::A_DSW: dsw_q <= pwdata;
				pcn_pkg::A_EDGE_CLOCK_TREE: ecl_q <= pwdata;
				default: ;
			endcase
		end
	end

	// Read multiplexer
	always_comb begin
		unique case (paddr)
			pcn_pkg::A_CTRL: rd_mux = ctrl_q;
			pcn_pkg::A_FBDIV: rd_mux = fbdiv_q;
			pcn_pkg::A_ODIV: rd_mux = odiv_q;
			pcn_pkg::A_PHASE: rd_mux = phase_q;
			pcn_pkg::A_GATE_LO: rd_mux = gate_lo_q;
			pcn_pkg::A_GATE_HI: rd_mux = gate_hi_q;
			pcn_pkg::A_QSEL: rd_mux = qsel_q;
			pcn_pkg::A_DSW: rd_mux = dsw_q;
			pcn_pkg::A_EDGE_CLOCK_TREE: rd_mux = ecl_q;
			pcn_pkg::A_STATUS: rd_mux = status;
			default: rd_mux = '0;
		endcase
	end

	// Read data captured in the setup cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata <= '0;
		end else if (psel && !penable) begin
			prdata <= rd_mux;
		end
	end

	// Reference selection and edge detection
	logic pll_off; // PLL held in reset or powered down
	logic ref_sel; // Chosen reference level
	logic ref_prev_q, fb_prev_q;
	logic ref_edge, fb_edge, fb_tick;
	logic [pcn_pkg::DIV_W-1:0] fb_cnt_q; // Feedback divider count
	logic [1:0] fb_seen_q; // Divided feedback edges this window
	logic win_good; // One feedback edge per reference edge
	assign pll_off = ctrl_q[pcn_pkg::CTRL_RST] || ctrl_q[pcn_pkg::CTRL_PDN];
	assign ref_sel = ctrl_q[pcn_pkg::CTRL_REF] ? alt_ref_clk_in : ref_clk_in;
	assign ref_edge = ref_sel && !ref_prev_q;
	assign fb_edge = feedback_clk && !fb_prev_q;
	// Ticks at or past the divide, so a lowered divide never waits for a wrap
	assign fb_tick = fb_edge && (fb_cnt_q >= fbdiv_q[pcn_pkg::DIV_W-1:0]);
	assign win_good = (fb_seen_q == 2'h0 && fb_tick) || (fb_seen_q == 2'h1 && !fb_tick);

	// Feedback divider and window counter
	always_ff @(posedge clk) begin
		if (srst || pll_off) begin
			ref_prev_q <= 1'b0;
			fb_prev_q <= 1'b0;
			fb_cnt_q <= '0;
			fb_seen_q <= 2'h0;
		end else begin
			ref_prev_q <= ref_sel;
			fb_prev_q <= feedback_clk;
			// Divide feedback edges by the programmed count plus one
			if (fb_edge) begin
				fb_cnt_q <= fb_tick ? '0 : fb_cnt_q + 1'b1;
			end
			// Count divided edges between reference edges
			if (ref_edge) begin
				fb_seen_q <= 2'h0;
			end else if (fb_tick && fb_seen_q != 2'h3) begin
				fb_seen_q <= fb_seen_q + 2'h1;
			end
		end
	end

	// Lock detector
	pcn_pkg::pcn_lock_t st_q, st_d;
	logic [CW-1:0] lk_cnt_q, lk_cnt_d; // Good windows in a row
	always_comb begin
		st_d = st_q;
		lk_cnt_d = lk_cnt_q;
		unique case (st_q)
			pcn_pkg::LK_OFF: begin
				lk_cnt_d = '0;
				if (!pll_off) begin
					st_d = pcn_pkg::LK_ACQ;
				end
			end
			pcn_pkg::LK_ACQ: begin
				if (ref_edge && !win_good) begin
					lk_cnt_d = '0;
				end else if (ref_edge && lk_cnt_q == CW'(LOCK_WINDOWS - 1)) begin
					st_d = pcn_pkg::LK_LOCKED;
				end else if (ref_edge) begin
					lk_cnt_d = lk_cnt_q + 1'b1;
				end
			end
			pcn_pkg::LK_LOCKED: begin
				if (ref_edge && !win_good) begin
					st_d = pcn_pkg::LK_ACQ;
					lk_cnt_d = '0;
				end
			end
			default: st_d = pcn_pkg::LK_OFF;
		endcase
		// Reset or power-down overrides everything
		if (pll_off) begin
			st_d = pcn_pkg::LK_OFF;
		end
	end

	// Lock state and flag registers
	always_ff @(posedge clk) begin
		if (srst) begin
			st_q <= pcn_pkg::LK_OFF;
			lk_cnt_q <= '0;
			pll_lock <= 1'b0;
		end else begin
			st_q <= st_d;
			lk_cnt_q <= lk_cnt_d;
			pll_lock <= (st_d == pcn_pkg::LK_LOCKED);
		end
	end

	// Phase offsets, pending and being issued
	logic signed [pcn_pkg::PH_W-1:0] pend_q [pcn_pkg::N_OUT];
	logic signed [pcn_pkg::PH_W-1:0] issue_q [pcn_pkg::N_OUT];
	logic [pcn_pkg::N_OUT-1:0] adv, dly; // Slip pulses to dividers
	logic [pcn_pkg::N_OUT-1:0] pll_outs; // Divided output clocks
	for (genvar i = 0; i < pcn_pkg::N_OUT; i++) begin : g_out
		logic signed [pcn_pkg::PH_W-1:0] delta, sum, mv;
		// Step lands only on the picked output
		assign delta = (step_pulse && step_pick == 2'(i))
			? (step_dir ? -pcn_pkg::PH_ONE : pcn_pkg::PH_ONE) : '0;
		assign sum = pend_q[i] + delta;
		assign adv[i] = issue_q[i] > 0;
		assign dly[i] = issue_q[i] < 0;
		assign mv = adv[i] ? pcn_pkg::PH_ONE : (dly[i] ? -pcn_pkg::PH_ONE : '0);
		// Apply moves pending steps into the issue counter
		always_ff @(posedge clk) begin
			if (srst) begin
				pend_q[i] <= '0;
				issue_q[i] <= '0;
			end else begin
				pend_q[i] <= apply_pulse ? '0 : sum;
				issue_q[i] <= issue_q[i] - mv + (apply_pulse ? sum : '0);
			end
		end
		// Divider for this output
		pcn_out_div #(
			.W(pcn_pkg::DIV_W)
		) u_div (
			.clk(clk),
			.srst(srst),
			.run(!pll_off),
			.gate_en(ctrl_q[pcn_pkg::CTRL_GATE + i]),
			.div_m1(odiv_q[i*pcn_pkg::DIV_STRIDE +: pcn_pkg::DIV_W]),
			.advance(adv[i]),
			.delay(dly[i]),
			.clk_out(pll_outs[i])
		);
	end
	assign pll_primary_out = pll_outs[0];
	assign pll_secondary_out_a = pll_outs[1];
	assign pll_secondary_out_b = pll_outs[2];
	assign pll_secondary_out_c = pll_outs[3];

	// Status word
	always_comb begin
		status = '0;
		status[pcn_pkg::ST_LOCK] = pll_lock;
		status[pcn_pkg::ST_OFF] = pll_off;
		status[pcn_pkg::ST_PEND +: pcn_pkg::PH_W] = pend_q[phase_q[pcn_pkg::PH_PICK +: 2]];
	end

	// Primary sources: external, then primary and secondaries b and c
	logic [pcn_pkg::N_SRC-1:0] src_all, mid_g;
	assign src_all = {pll_outs[3], pll_outs[2], pll_outs[0], ext_src_clk};
	for (genvar k = 0; k < pcn_pkg::N_SRC; k++) begin : g_gate
		// Gate after the mid switch, before the centre switch
		pcn_qgate u_gate (
			.clk(clk),
			.srst(srst),
			.clk_in(src_all[k]),
			.en(k < 32 ? gate_lo_q[k % 32] : gate_hi_q[k % 32]),
			.clk_out(mid_g[k])
		);
	end

	// Dynamic clock switches
	logic [pcn_pkg::N_DSW-1:0] dsw_a, dsw_out, dsw_cur_q, dsw_cur_d;
	for (genvar j = 0; j < pcn_pkg::N_DSW; j++) begin : g_dsw
		logic [7:0] cfg;
		logic both_low;
		assign cfg = dsw_q[j*pcn_pkg::DSW_STRIDE +: pcn_pkg::DSW_STRIDE];
		assign dsw_a[j] = mid_g[cfg[pcn_pkg::DSW_SRC_W-1:0]];
		assign both_low = !dsw_a[j] && !fabric_centre_clk[j];
		// Glitchless mode changes over only while both clocks are low
		assign dsw_cur_d[j] = (!cfg[pcn_pkg::DSW_MODE] || both_low)
			? cfg[pcn_pkg::DSW_SEL] : dsw_cur_q[j];
		always_ff @(posedge clk) begin
			if (srst) begin
				dsw_cur_q[j] <= 1'b0;
				dsw_out[j] <= 1'b0;
			end else begin
				dsw_cur_q[j] <= dsw_cur_d[j];
				dsw_out[j] <= dsw_cur_d[j] ? fabric_centre_clk[j] : dsw_a[j];
			end
		end
	end

	// Centre switch: each quadrant takes one mid group, last slots may take switches
	for (genvar q = 0; q < pcn_pkg::N_QUAD; q++) begin : g_quad
		for (genvar s = 0; s < pcn_pkg::Q_CLKS; s++) begin : g_slot
			logic [5:0] midx;
			assign midx = {qsel_q[q*pcn_pkg::QSEL_W +: pcn_pkg::QSEL_W], 4'(s)};
			if (s >= SW0) begin : g_sw
				assign quad_clk[q*pcn_pkg::Q_CLKS + s] =
					qsel_q[pcn_pkg::QSUB + q*pcn_pkg::N_DSW + s - SW0]
					? dsw_out[s - SW0] : mid_g[midx];
			end else begin : g_plain
				assign quad_clk[q*pcn_pkg::Q_CLKS + s] = mid_g[midx];
			end
		end
	end

	// Edge clock source selection, registered per net
	for (genvar n = 0; n < N_EDGE_CLOCK_TREE; n++) begin : g_edge_clock_tree
		pcn_pkg::pcn_edge_clock_tree_t esel;
		logic e_d;
		assign esel = pcn_pkg::pcn_edge_clock_tree_t'(ecl_q[n*pcn_pkg::EDGE_CLOCK_TREE_W +: pcn_pkg::EDGE_CLOCK_TREE_W]);
		always_comb begin
			unique case (esel)
				pcn_pkg::EDGE_CLOCK_TREE_PIN: e_d = edge_clock_tree_pin_clk[n];
				pcn_pkg::EDGE_CLOCK_TREE_DELAY: e_d = edge_clock_tree_delay_clk;
				pcn_pkg::EDGE_CLOCK_TREE_PRI: e_d = pll_outs[0];
				pcn_pkg::EDGE_CLOCK_TREE_SECA: e_d = pll_outs[1];
				pcn_pkg::EDGE_CLOCK_TREE_BRIDGE: e_d = edge_clock_tree_bridge_clk;
				pcn_pkg::EDGE_CLOCK_TREE_INTERNAL: e_d = edge_clock_tree_internal_clk;
				default: e_d = 1'b0;
			endcase
		end
		always_ff @(posedge clk) begin
			if (srst) begin
				edge_clock_tree[n] <= 1'b0;
			end else begin
				edge_clock_tree[n] <= e_d;
			end
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence gate_off_s;
		!gate_lo_q[0] && !src_all[0];
	endsequence

	lock_in_reset_a: assert property (ctrl_q[pcn_pkg::CTRL_RST] |=> !pll_lock)
		else $error("lock high while PLL reset");
	lock_loss_a: assert property ((st_q == pcn_pkg::LK_LOCKED && ref_edge && !win_good
		&& !pll_off) |=> !pll_lock)
		else $error("lock kept after bad window");
	lock_rise_a: assert property ($rose(pll_lock) |-> $past(st_q) == pcn_pkg::LK_ACQ)
		else $error("lock rose without acquisition");
	pdn_quiet_a: assert property (ctrl_q[pcn_pkg::CTRL_PDN] |=> pll_outs == '0)
		else $error("output toggling in power-down");
	out_enable_a: assert property (!ctrl_q[pcn_pkg::CTRL_GATE] |=> !pll_primary_out)
		else $error("disabled primary output high");
	gate_hold_a: assert property ((gate_off_s ##1 !gate_lo_q[0]) |-> !mid_g[0] ##1 !mid_g[0])
		else $error("gated clock not static");
	gate_clean_a: assert property ($fell(mid_g[0]) |-> !$past(src_all[0]))
		else $error("gated clock pulse cut short");
	dsw_plain_a: assert property (!dsw_q[pcn_pkg::DSW_MODE] |=> dsw_out[0]
		== $past(dsw_q[pcn_pkg::DSW_SEL] ? fabric_centre_clk[0] : dsw_a[0]))
		else $error("plain switch output wrong");
	step_hold_a: assert property ((!step_pulse && !apply_pulse) |=> $stable(pend_q[1]))
		else $error("pending phase moved without step");
	pick_step_a: assert property ((step_pulse && !apply_pulse && step_pick == 2'h2)
		|=> pend_q[2] != $past(pend_q[2]))
		else $error("picked output not stepped");
	edge_clock_tree_pri_a: assert property ((ecl_q[pcn_pkg::EDGE_CLOCK_TREE_W-1:0] == pcn_pkg::EDGE_CLOCK_TREE_PRI)
		|=> edge_clock_tree[0] == $past(pll_outs[0]))
		else $error("edge clock not from primary");
endmodule
`default_nettype wire

// *** hdl/pcn_out_div.sv ***
// One PLL output divider with enable and phase slip.
// Assumes run, gate_en and the step pulses are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pcn_out_div #(
	parameter int unsigned W = 7
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic run,
	input wire logic gate_en,
	input wire logic [W-1:0] div_m1,
	input wire logic advance,
	input wire logic delay,
	// Divided clock
	output logic clk_out
);
	logic [W-1:0] cnt_q; // Tick counter
	logic tog_q; // Free running divided level
	logic extra; // Count twice to advance
	logic [W:0] nxt; // Count after this tick
	logic wrap; // Half period ends
	logic [W:0] span; // Divide value as a count

	// Advance impossible when dividing by one
	assign extra = advance && (div_m1 != '0);
	assign nxt = {1'b0, cnt_q} + (W+1)'(1) + (W+1)'(extra);
	assign span = {1'b0, div_m1} + (W+1)'(1);
	assign wrap = nxt >= span;

	// Counter holds one tick on a delay step
	always_ff @(posedge clk) begin
		if (srst || !run) begin
			cnt_q <= '0;
			tog_q <= 1'b0;
		end else if (!delay) begin
			cnt_q <= wrap ? W'(nxt - span) : W'(nxt);
			tog_q <= tog_q ^ wrap;
		end
	end

	// Output gated per output, divider keeps phase
	always_ff @(posedge clk) begin
		if (srst) begin
			clk_out <= 1'b0;
		end else begin
			clk_out <= run && gate_en && tog_q;
		end
	end
endmodule
`default_nettype wire

// *** hdl/pcn_pkg.sv ***
// Constants and types of the PLL and clock network control block.
// Assumes a 32-bit APB slave, one aligned word per register.
package pcn_pkg;
	// Structure sizes
	localparam int unsigned N_OUT = 4;
	localparam int unsigned DIV_W = 7;
	localparam int unsigned N_SRC = 64;
	localparam int unsigned N_EXT = 61;
	localparam int unsigned N_QUAD = 4;
	localparam int unsigned Q_CLKS = 16;
	localparam int unsigned N_DSW = 2;
	localparam int unsigned PH_W = 8;
	localparam int unsigned EDGE_CLOCK_TREE_W = 3;
	// Register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_FBDIV = 8'h04;
	localparam logic [7:0] A_ODIV = 8'h08;
	localparam logic [7:0] A_PHASE = 8'h0C;
	localparam logic [7:0] A_GATE_LO = 8'h10;
	localparam logic [7:0] A_GATE_HI = 8'h14;
	localparam logic [7:0] A_QSEL = 8'h18;
	localparam logic [7:0] A_DSW = 8'h1C;
	localparam logic [7:0] A_EDGE_CLOCK_TREE = 8'h20;
	localparam logic [7:0] A_STATUS = 8'h24;
	// Control register fields
	localparam int unsigned CTRL_REF = 0;
	localparam int unsigned CTRL_PDN = 1;
	localparam int unsigned CTRL_RST = 2;
	localparam int unsigned CTRL_GATE = 4;
	// Phase register fields
	localparam int unsigned PH_PICK = 0;
	localparam int unsigned PH_DIR = 2;
	localparam int unsigned PH_STEP = 3;
	localparam int unsigned PH_APPLY = 4;
	// Strides and positions of packed fields
	localparam int unsigned DIV_STRIDE = 8;
	localparam int unsigned DSW_STRIDE = 8;
	localparam int unsigned DSW_SRC_W = 6;
	localparam int unsigned DSW_SEL = 6;
	localparam int unsigned DSW_MODE = 7;
	localparam int unsigned QSEL_W = 2;
	localparam int unsigned QSUB = 8;
	localparam int unsigned ST_LOCK = 0;
	localparam int unsigned ST_OFF = 1;
	localparam int unsigned ST_PEND = 8;
	// Reset values
	localparam logic [31:0] CTRL_INIT = 32'h0000_00F0;
	localparam logic [31:0] ZERO_INIT = 32'h0000_0000;
	localparam logic [31:0] GATE_INIT = 32'hFFFF_FFFF;
	localparam logic [31:0] QSEL_INIT = 32'h0000_00E4;
	localparam logic [31:0] DSW_INIT = 32'h0000_8080;
	// One phase step
	localparam logic signed [PH_W-1:0] PH_ONE = 8'sh01;
	// Edge clock source codes
	typedef enum logic [2:0] {
		EDGE_CLOCK_TREE_PIN = 3'h0,
		EDGE_CLOCK_TREE_DELAY = 3'h1,
		EDGE_CLOCK_TREE_PRI = 3'h2,
		EDGE_CLOCK_TREE_SECA = 3'h3,
		EDGE_CLOCK_TREE_BRIDGE = 3'h4,
		EDGE_CLOCK_TREE_INTERNAL = 3'h5
	} pcn_edge_clock_tree_t;
	// Lock detector states
	typedef enum logic [1:0] {
		LK_OFF = 2'h0,
		LK_ACQ = 2'h1,
		LK_LOCKED = 2'h2
	} pcn_lock_t;
endpackage

// *** hdl/pcn_qgate.sv ***
// Glitchless gate for one clock of the primary tree.
// Assumes clk_in is a clock level sampled on clk.
`timescale 1ns/1ps
`default_nettype none
module pcn_qgate (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Gated clock
	input wire logic clk_in,
	input wire logic en,
	output logic clk_out
);
	logic en_q; // Enable seen by the clock
	logic en_nx; // Enable for this edge

	// Enable only moves while the clock is low
	assign en_nx = clk_in ? en_q : en;

	// Register the gated clock
	always_ff @(posedge clk) begin
		if (srst) begin
			en_q <= 1'b1;
			clk_out <= 1'b0;
		end else begin
			en_q <= en_nx;
			clk_out <= clk_in && en_nx;
		end
	end
endmodule
`default_nettype wire

// *** testbench/pcn_fabric_model.sv ***
// Fabric-side model: reference, feedback and source clocks for the block.
// Assumes clk is the bench clock; every clock here is a level made on it.
`timescale 1ns/1ps
`default_nettype none
module pcn_fabric_model (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Feedback mode: 0 same rate, 1 double rate, 2 stopped
	input wire logic [1:0] fb_mode,
	// Clocks to the block
	output logic ref_clk_in,
	output logic alt_ref_clk_in,
	output logic feedback_clk,
	output logic [60:0] ext_src_clk,
	output logic [1:0] fabric_centre_clk,
	output logic [7:0] edge_clock_tree_pin_clk,
	output logic [2:0] edge_clock_tree_misc
);
	logic [4:0] cnt_q; // Free-running phase counter
	logic [4:0] lag; // Feedback phase, kept off the reference edge
	// Count clock cycles
	always_ff @(posedge clk) begin
		cnt_q <= srst ? 5'h00 : cnt_q + 5'h01;
	end
	assign lag = cnt_q + 5'h01;
	// Reference period 8, alternate reference period 16
	assign ref_clk_in = cnt_q[2];
	assign alt_ref_clk_in = cnt_q[3];
	// Feedback at the reference rate, double rate, or stopped
	assign feedback_clk = (fb_mode == 2'h0) ? lag[2] : (fb_mode == 2'h1) ? lag[1] : 1'b0;
	// Both switch inputs always run
	assign ext_src_clk = {61{cnt_q[1]}};
	assign fabric_centre_clk = {2{cnt_q[3]}};
	// Edge sources: pins period 4, delay 8, bridge 16, internal 32
	assign edge_clock_tree_pin_clk = {8{cnt_q[1]}};
	assign edge_clock_tree_misc = {cnt_q[4], cnt_q[3], cnt_q[2]};
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench: APB register tasks and clock rate counting.
// Assumes pcn_clock_ctrl and the fabric model; lock window count 2.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, st;
	logic pri, sa, sb, sc, lock, refc, altc, fbc;
	logic [1:0] fb_mode, fcc, lk_q;
	logic [2:0] misc;
	logic [60:0] ext;
	logic [63:0] quad;
	logic [7:0] pins, edge_n;
	logic [8:0] pv;
	int bad_count, compares;
	int exp_e [7] = '{24, 12, 48, 16, 6, 3, 0}; // Edge rises per source code
	pcn_clock_ctrl #(.LOCK_WINDOWS(2), .N_EBANK(4)) u_pcn_clock_ctrl (.clk(clk), .srst(srst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_clk_in(refc),
		.alt_ref_clk_in(altc), .feedback_clk(fbc), .pll_primary_out(pri),
		.pll_secondary_out_a(sa), .pll_secondary_out_b(sb), .pll_secondary_out_c(sc),
		.pll_lock(lock), .ext_src_clk(ext), .fabric_centre_clk(fcc), .quad_clk(quad),
		.edge_clock_tree_pin_clk(pins), .edge_clock_tree_delay_clk(misc[0]), .edge_clock_tree_bridge_clk(misc[1]),
		.edge_clock_tree_internal_clk(misc[2]), .edge_clock_tree(edge_n));
	pcn_fabric_model u_pcn_fabric_model (.clk(clk), .srst(srst), .fb_mode(fb_mode),
		.ref_clk_in(refc), .alt_ref_clk_in(altc), .feedback_clk(fbc), .ext_src_clk(ext),
		.fabric_centre_clk(fcc), .edge_clock_tree_pin_clk(pins), .edge_clock_tree_misc(misc));
	// Probes: gated slots, divider outputs, edge net 0
	assign pv = {sc, edge_n[0], sb, sa, pri, quad[48], quad[13], quad[14], quad[0]};
	// Two-stage synchroniser before lock is used
	always @(posedge clk) lk_q <= {lk_q[0], lock};
	// Clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task automatic test_done();
		if (bad_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// One APB transfer, starting just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		check({31'h0, pready}, 32'h0000_0001);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Write, expecting no error
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		check({31'h0, e}, 32'h0000_0000);
	endtask
	// Read into st
	task automatic rd(input logic [7:0] a);
		logic e;
		apb(1'b0, a, 32'h0000_0000, st, e);
	endtask
	// Count rising edges of probe i over len cycles after settling
	task automatic rises(input int i, input int len, input int want);
		int n;
		logic p;
		n = 0;
		repeat (24) @(posedge clk);
		@(negedge clk);
		p = pv[i];
		repeat (len) begin
			@(negedge clk);
			if (pv[i] === 1'b1 && p === 1'b0) n++;
			p = pv[i];
		end
		@(posedge clk);
		check(32'(n), 32'(want));
	endtask
	// Wait for the synchronised lock to reach a level
	task automatic wait_lock(input logic want);
		int n;
		n = 0;
		while (lk_q[1] !== want && n < 400) begin
			@(posedge clk);
			n++;
		end
		check({31'h0, lk_q[1]}, {31'h0, want});
	endtask
	// Watchdog
	initial begin
		#400000;
		bad_count++;
		test_done();
	end
	// Main sequence
	initial begin
		logic e;
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		fb_mode = 2'h0;
		bad_count = 0;
		compares = 0;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		// Reset values
		rd(pcn_pkg::A_CTRL);
		check(st, pcn_pkg::CTRL_INIT);
		rd(pcn_pkg::A_GATE_HI);
		check(st, pcn_pkg::GATE_INIT);
		rd(pcn_pkg::A_QSEL);
		check(st, pcn_pkg::QSEL_INIT);
		rd(pcn_pkg::A_DSW);
		check(st, pcn_pkg::DSW_INIT);
		rd(pcn_pkg::A_ODIV);
		check(st, pcn_pkg::ZERO_INIT);
		// Unmapped read and status write are refused
		apb(1'b0, 8'h28, 32'h0000_0000, st, e);
		check({st[31:1], e}, 32'h0000_0001);
		apb(1'b1, pcn_pkg::A_STATUS, 32'hFFFF_FFFF, st, e);
		check({31'h0, e}, 32'h0000_0001);
		// Lock, loss of lock, feedback divider
		wait_lock(1'b1);
		rd(pcn_pkg::A_STATUS);
		check(st[1:0], 32'h0000_0001);
		fb_mode <= 2'h1;
		wait_lock(1'b0);
		wr(pcn_pkg::A_FBDIV, 32'h0000_0001);
		wait_lock(1'b1);
		fb_mode <= 2'h2;
		wait_lock(1'b0);
		wr(pcn_pkg::A_FBDIV, 32'h0000_0000);
		fb_mode <= 2'h0;
		wait_lock(1'b1);
		// Alternate reference runs at another rate; then reset and power-down hold the PLL off
		wr(pcn_pkg::A_CTRL, 32'h0000_00F1);
		wait_lock(1'b0);
		wr(pcn_pkg::A_CTRL, 32'h0000_00F4);
		repeat (40) @(posedge clk);
		wait_lock(1'b0);
		rd(pcn_pkg::A_STATUS);
		check(st[1:0], 32'h0000_0002);
		wr(pcn_pkg::A_CTRL, 32'h0000_00F2);
		rises(4, 96, 0);
		wait_lock(1'b0);
		wr(pcn_pkg::A_CTRL, 32'h0000_00F0);
		wait_lock(1'b1);
		// Dividers 1, 3 and 128
		wr(pcn_pkg::A_ODIV, 32'h007F_0200);
		rises(4, 96, 48);
		rises(5, 96, 16);
		rises(6, 512, 2);
		rises(8, 96, 48);
		wr(pcn_pkg::A_CTRL, 32'h0000_00E0);
		rises(4, 96, 0);
		rises(5, 96, 16);
		wr(pcn_pkg::A_CTRL, 32'h0000_00F0);
		// Quadrant gate on sources 0 and 48
		rises(0, 96, 24);
		wr(pcn_pkg::A_GATE_LO, 32'hFFFF_FFFE);
		rises(0, 96, 0);
		wr(pcn_pkg::A_GATE_LO, 32'hFFFF_FFFF);
		rises(0, 96, 24);
		wr(pcn_pkg::A_GATE_HI, 32'hFFFE_FFFF);
		rises(3, 96, 0);
		wr(pcn_pkg::A_GATE_HI, 32'hFFFF_FFFF);
		rises(3, 96, 24);
		// Group 3 slot 13 carries the primary output
		wr(pcn_pkg::A_QSEL, 32'h0000_00E7);
		rises(2, 96, 48);
		// Dynamic switch 0 on quadrant 0 slot 14
		wr(pcn_pkg::A_QSEL, 32'h0000_01E4);
		rises(1, 96, 24);
		wr(pcn_pkg::A_DSW, 32'h0000_8040);
		rises(1, 96, 6);
		wr(pcn_pkg::A_DSW, 32'h0000_8080);
		rises(1, 96, 24);
		wr(pcn_pkg::A_DSW, 32'h0000_80C0);
		rises(1, 96, 6);
		// Every edge source code, then an unused one
		for (int c = 0; c < 7; c++) begin
			wr(pcn_pkg::A_EDGE_CLOCK_TREE, 32'(c));
			rises(7, 96, exp_e[c]);
		end
		// Steps pend per picked output until applied
		wr(pcn_pkg::A_PHASE, 32'h0000_0009);
		wr(pcn_pkg::A_PHASE, 32'h0000_0009);
		rd(pcn_pkg::A_STATUS);
		check(st[15:8], 32'h0000_0002);
		wr(pcn_pkg::A_PHASE, 32'h0000_0002);
		rd(pcn_pkg::A_STATUS);
		check(st[15:8], 32'h0000_0000);
		wr(pcn_pkg::A_PHASE, 32'h0000_0011);
		rd(pcn_pkg::A_STATUS);
		check(st[15:8], 32'h0000_0000);
		wr(pcn_pkg::A_PHASE, 32'h0000_000D);
		rd(pcn_pkg::A_STATUS);
		check(st[15:8], 32'h0000_00FF);
		wr(pcn_pkg::A_PHASE, 32'h0000_000A);
		rd(pcn_pkg::A_STATUS);
		check(st[15:8], 32'h0000_0001);
		test_done();
	end
endmodule
`default_nettype wire
